// file: hw/rsc_map.vh
/*
 * Register map, field positions, reset values and widths of the reset
 * strap configuration sampler.
 * Assumes it is included by its bare name from each design file that needs it.
 */
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define RSC_ADDR_CONFIG    4'h0
`define RSC_ADDR_STATUS    4'h4
`define RSC_ADDR_CONTROL   4'h8
`define RSC_ADDR_LIVE      4'hC
`define RSC_ADDR_W         4

// ----------------------------------------------------------------------
// Strap vector layout, also the layout of the config register
// ----------------------------------------------------------------------
`define RSC_OPT_TRISTATE   0
`define RSC_OPT_BIST       1
`define RSC_OPT_IOQ_ONE    2
`define RSC_OPT_MCHK_DIS   3
`define RSC_OPT_BUS_INIT_SIGNAL_DIS  4
`define RSC_OPT_CLUS_LO    5
`define RSC_OPT_CLUS_HI    6
`define RSC_OPT_PARK_DIS   7
`define RSC_OPT_MT_DIS     8
`define RSC_OPT_ARB_ID     9
`define RSC_OPT_W          10
`define RSC_RSV_W          27
`define RSC_SYNC_W         38

// ----------------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------------
`define RSC_STS_VALID      0
`define RSC_STS_IN_RESET   1
`define RSC_STS_RSV_SEEN   2
`define RSC_STS_CNT_LO     8
`define RSC_STS_CNT_HI     15
`define RSC_CTL_CLR_RSV    0
`define RSC_CTL_CLR_CNT    1
`define RSC_CNT_W          8

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define RSC_CFG_RST        10'h000
`define RSC_CNT_RST        8'h00
`define RSC_SYNC_RST       38'h3FFFFFFFFE
`define RSC_RESP_OKAY      2'h0
`define RSC_RESP_SLVERR    2'h2

`endif

// file: hw/rsc_sync.v
/*
 * Two-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level from a pin; no bus coherence is implied.
 */
`timescale 1ns/1ns

module rsc_sync #(
    parameter W       = 1,
    parameter RST_VAL = 1'b0
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

// ----------------------------------------------------------------------
// Synchroniser stages
// ----------------------------------------------------------------------
reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

// First stage feeds only the second stage
always @(posedge aclk) begin
    if (!aresetn) begin
        meta_q <= RST_VAL;
        sync_q <= RST_VAL;
    end else begin
        meta_q <= d;
        sync_q <= meta_q;
    end
end

assign q = sync_q;

endmodule

// file: hw/rsc_axil.v
/*
 * AXI4-Lite slave front end: takes address and data in either order,
 * issues one write strobe, answers reads one cycle after the address.
 * Assumes the register side decodes addresses combinationally.
 */
`timescale 1ns/1ns

`include "rsc_map.vh"

module rsc_axil (
    input  wire                    aclk,
    input  wire                    aresetn,
    input  wire [`RSC_ADDR_W-1:0]  awaddr,
    input  wire                    awvalid,
    output wire                    awready,
    input  wire [31:0]             wdata,
    input  wire [3:0]              wstrb,
    input  wire                    wvalid,
    output wire                    wready,
    output wire [1:0]              bresp,
    output wire                    bvalid,
    input  wire                    bready,
    input  wire [`RSC_ADDR_W-1:0]  araddr,
    input  wire                    arvalid,
    output wire                    arready,
    output wire [31:0]             rdata,
    output wire [1:0]              rresp,
    output wire                    rvalid,
    input  wire                    rready,
    output wire                    wr_en,
    output wire [`RSC_ADDR_W-1:0]  wr_addr,
    output wire [31:0]             wr_data,
    output wire [3:0]              wr_strb,
    input  wire                    wr_ok,
    input  wire [31:0]             rd_data,
    input  wire                    rd_ok
);

// ----------------------------------------------------------------------
// Write channels
// ----------------------------------------------------------------------
reg                   aw_hold_q;
reg                   w_hold_q;
reg [`RSC_ADDR_W-1:0] awaddr_q;
reg [31:0]            wdata_q;
reg [3:0]             wstrb_q;
reg                   awready_q;
reg                   wready_q;
reg                   bvalid_q;
reg [1:0]             bresp_q;
reg                   aw_hold_d;
reg                   w_hold_d;
reg                   bvalid_d;
wire                  wr_fire;

// Both halves held and no answer pending
assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;

// Next state of the holding flags and the response
always @* begin
    aw_hold_d = aw_hold_q ? ~wr_fire : (awvalid & awready_q);
    w_hold_d  = w_hold_q  ? ~wr_fire : (wvalid & wready_q);
    bvalid_d  = bvalid_q  ? ~bready  : wr_fire;
end

// Ready is registered so it never depends on valid in the same cycle
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        awaddr_q  <= {`RSC_ADDR_W{1'b0}};
        wdata_q   <= 32'h0000_0000;
        wstrb_q   <= 4'h0;
        awready_q <= 1'b0;
        wready_q  <= 1'b0;
        bvalid_q  <= 1'b0;
        bresp_q   <= `RSC_RESP_OKAY;
    end else begin
        aw_hold_q <= aw_hold_d;
        w_hold_q  <= w_hold_d;
        awready_q <= ~aw_hold_d & ~bvalid_d;
        wready_q  <= ~w_hold_d & ~bvalid_d;
        bvalid_q  <= bvalid_d;
        if (awvalid && awready_q) begin
            awaddr_q <= awaddr;
        end
        if (wvalid && wready_q) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end
        if (wr_fire) begin
            bresp_q <= wr_ok ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
        end
    end
end

assign awready = awready_q;
assign wready  = wready_q;
assign bvalid  = bvalid_q;
assign bresp   = bresp_q;
assign wr_en   = wr_fire;
assign wr_addr = awaddr_q;
assign wr_data = wdata_q;
assign wr_strb = wstrb_q;

// ----------------------------------------------------------------------
// Read channels
// ----------------------------------------------------------------------
reg        arready_q;
reg        rvalid_q;
reg [31:0] rdata_q;
reg [1:0]  rresp_q;
reg        rvalid_d;

always @* begin
    rvalid_d = rvalid_q ? ~rready : (arvalid & arready_q);
end

// Data are captured at the address edge and held until taken
always @(posedge aclk) begin
    if (!aresetn) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b0;
        rdata_q   <= 32'h0000_0000;
        rresp_q   <= `RSC_RESP_OKAY;
    end else begin
        arready_q <= ~rvalid_d;
        rvalid_q  <= rvalid_d;
        if (arvalid && arready_q) begin
            rdata_q <= rd_ok ? rd_data : 32'h0000_0000;
            rresp_q <= rd_ok ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
        end
    end
end

assign arready = arready_q;
assign rvalid  = rvalid_q;
assign rdata   = rdata_q;
assign rresp   = rresp_q;

endmodule

// file: hw/rsc_sampler.v
/*
 * Reset strap configuration sampler: catches the option straps on the
 * release of the device reset pin and holds the options until the next one.
 * Assumes straps and the reset pin are asynchronous levels from the board,
 * held stable around the release, and an AXI4-Lite master on aclk.
 */
// Notes on behaviour
// - Capture strap levels at reset release
// - Captured options change only on reset
// - Every reset recaptures, warm or cold
// - Strap held asserted during reset selects option
// - Each option has its own strap
// - Queue-depth strap limits queue to one
// - Cluster id from two address straps
// - Arbitration id from bus-request strap
// - Tristate from mgmt irq, self-test from init
`timescale 1ns/1ns

`include "rsc_map.vh"

module rsc_sampler (
    input  wire                    aclk,
    input  wire                    aresetn,
    input  wire                    sys_reset_n,
    input  wire                    sys_mgmt_irq_strap_n,
    input  wire                    bist_strap_n,
    input  wire                    queue_depth_strap_n,
    input  wire                    mcheck_obs_disable_strap_n,
    input  wire                    businit_obs_disable_strap_n,
    input  wire [1:0]              cluster_id_strap_n,
    input  wire                    parking_disable_strap_n,
    input  wire                    multithread_disable_strap_n,
    input  wire                    arb_id_strap_n,
    input  wire [`RSC_RSV_W-1:0]   reserved_strap_n,
    input  wire [`RSC_ADDR_W-1:0]  s_axi_awaddr,
    input  wire                    s_axi_awvalid,
    output wire                    s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output wire                    s_axi_wready,
    output wire [1:0]              s_axi_bresp,
    output wire                    s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [`RSC_ADDR_W-1:0]  s_axi_araddr,
    input  wire                    s_axi_arvalid,
    output wire                    s_axi_arready,
    output wire [31:0]             s_axi_rdata,
    output wire [1:0]              s_axi_rresp,
    output wire                    s_axi_rvalid,
    input  wire                    s_axi_rready,
    output wire                    cfg_valid,
    output wire                    cfg_output_tristate,
    output wire                    cfg_run_bist,
    output wire                    cfg_ioq_depth_one,
    output wire                    cfg_mcheck_obs_disable,
    output wire                    cfg_businit_obs_disable,
    output wire [1:0]              cfg_cluster_id,
    output wire                    cfg_parking_disable,
    output wire                    cfg_multithread_disable,
    output wire                    cfg_arb_id
);

// ----------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------

// Word-aligned hit on one of the four registers
function addr_hit;
    input [`RSC_ADDR_W-1:0] a;
    begin
        addr_hit = (a[1:0] == 2'h0);
    end
endfunction

// ----------------------------------------------------------------------
// Pin synchronisation
// ----------------------------------------------------------------------
wire [`RSC_OPT_W-1:0]  opt_pins_n;
wire [`RSC_SYNC_W-1:0] pins_raw;
wire [`RSC_SYNC_W-1:0] pins_s;
wire                   rst_pin_s;
wire [`RSC_OPT_W-1:0]  opt_s_n;
wire [`RSC_RSV_W-1:0]  rsv_s_n;

// Each option strap sits on its own bit of the vector
assign opt_pins_n = {arb_id_strap_n,
                     multithread_disable_strap_n,
                     parking_disable_strap_n,
                     cluster_id_strap_n,
                     businit_obs_disable_strap_n,
                     mcheck_obs_disable_strap_n,
                     queue_depth_strap_n,
                     bist_strap_n,
                     sys_mgmt_irq_strap_n};

// Reset pin rides with the straps so both see the same delay
assign pins_raw = {reserved_strap_n, opt_pins_n, sys_reset_n};

rsc_sync #(
    .W       (`RSC_SYNC_W),
    .RST_VAL (`RSC_SYNC_RST)
) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pins_raw),
    .q       (pins_s)
);

assign rst_pin_s = pins_s[0];
assign opt_s_n   = pins_s[`RSC_OPT_W:1];
assign rsv_s_n   = pins_s[`RSC_SYNC_W-1:`RSC_OPT_W+1];

// ----------------------------------------------------------------------
// Release detection
// ----------------------------------------------------------------------
reg                  rst_pin_d_q;
reg [`RSC_OPT_W-1:0] opt_d_n_q;
reg [`RSC_RSV_W-1:0] rsv_d_n_q;
wire                 release_evt;

// One cycle of history: the levels seen while reset was still low
always @(posedge aclk) begin
    if (!aresetn) begin
        rst_pin_d_q <= 1'b0;
        opt_d_n_q   <= {`RSC_OPT_W{1'b1}};
        rsv_d_n_q   <= {`RSC_RSV_W{1'b1}};
    end else begin
        rst_pin_d_q <= rst_pin_s;
        opt_d_n_q   <= opt_s_n;
        rsv_d_n_q   <= rsv_s_n;
    end
end

// Low-to-high edge of the reset pin, same for warm and cold resets
assign release_evt = rst_pin_s & ~rst_pin_d_q;

// ----------------------------------------------------------------------
// Register bus front end
// ----------------------------------------------------------------------
wire                   wr_en;
wire [`RSC_ADDR_W-1:0] wr_addr;
wire [31:0]            wr_data;
wire [3:0]             wr_strb;
reg  [31:0]            rd_data;

rsc_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (addr_hit(wr_addr)),
    .rd_data (rd_data),
    .rd_ok   (addr_hit(s_axi_araddr))
);

// Control strobes act only through the low byte lane
wire ctl_wr;
wire clr_rsv;
wire clr_cnt;

assign ctl_wr  = wr_en & (wr_addr == `RSC_ADDR_CONTROL) & wr_strb[0];
assign clr_rsv = ctl_wr & wr_data[`RSC_CTL_CLR_RSV];
assign clr_cnt = ctl_wr & wr_data[`RSC_CTL_CLR_CNT];

// ----------------------------------------------------------------------
// Captured configuration
// ----------------------------------------------------------------------
reg [`RSC_OPT_W-1:0] cfg_q;
reg                  valid_q;
reg                  rsv_seen_q;
reg [`RSC_CNT_W-1:0] cnt_q;

// Options load only at the release; no bus write reaches them.
// The pre-release copy is used so a strap dropped on the very edge of
// the release is still seen as held through reset.
always @(posedge aclk) begin
    if (!aresetn) begin
        cfg_q   <= `RSC_CFG_RST;
        valid_q <= 1'b0;
    end else if (release_evt) begin
        cfg_q   <= ~opt_d_n_q;
        valid_q <= 1'b1;
    end else if (!rst_pin_s) begin
        valid_q <= 1'b0;
    end
end

// Reserved straps seen low at release leave a sticky mark; set beats clear
always @(posedge aclk) begin
    if (!aresetn) begin
        rsv_seen_q <= 1'b0;
    end else if (release_evt && (rsv_d_n_q != {`RSC_RSV_W{1'b1}})) begin
        rsv_seen_q <= 1'b1;
    end else if (clr_rsv) begin
        rsv_seen_q <= 1'b0;
    end
end

// Count of captures, wraps; a capture in the clear cycle counts as one
always @(posedge aclk) begin
    if (!aresetn) begin
        cnt_q <= `RSC_CNT_RST;
    end else if (release_evt) begin
        cnt_q <= clr_cnt ? 8'h01 : cnt_q + 8'h01;
    end else if (clr_cnt) begin
        cnt_q <= `RSC_CNT_RST;
    end
end

// ----------------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------------

// Unused bits read as zero; control reads back as zero
always @* begin
    rd_data = 32'h0000_0000;
    case (s_axi_araddr)
        `RSC_ADDR_CONFIG: begin
            rd_data[`RSC_OPT_W-1:0] = cfg_q;
        end
        `RSC_ADDR_STATUS: begin
            rd_data[`RSC_STS_VALID]                  = valid_q;
            rd_data[`RSC_STS_IN_RESET]               = ~rst_pin_s;
            rd_data[`RSC_STS_RSV_SEEN]               = rsv_seen_q;
            rd_data[`RSC_STS_CNT_HI:`RSC_STS_CNT_LO] = cnt_q;
        end
        `RSC_ADDR_LIVE: begin
            rd_data[`RSC_OPT_W-1:0] = ~opt_s_n;
        end
        default: begin
            rd_data = 32'h0000_0000;
        end
    endcase
end

// ----------------------------------------------------------------------
// Option outputs, straight from the capture register
// ----------------------------------------------------------------------
assign cfg_valid               = valid_q;
assign cfg_output_tristate     = cfg_q[`RSC_OPT_TRISTATE];
assign cfg_run_bist            = cfg_q[`RSC_OPT_BIST];
assign cfg_ioq_depth_one       = cfg_q[`RSC_OPT_IOQ_ONE];
assign cfg_mcheck_obs_disable  = cfg_q[`RSC_OPT_MCHK_DIS];
assign cfg_businit_obs_disable = cfg_q[`RSC_OPT_BUS_INIT_SIGNAL_DIS];
assign cfg_cluster_id          = cfg_q[`RSC_OPT_CLUS_HI:`RSC_OPT_CLUS_LO];
assign cfg_parking_disable     = cfg_q[`RSC_OPT_PARK_DIS];
assign cfg_multithread_disable = cfg_q[`RSC_OPT_MT_DIS];
assign cfg_arb_id              = cfg_q[`RSC_OPT_ARB_ID];

endmodule

// file: verification/rsc_monitor.sv
/* Port checks of the strap sampler.
   Assumes one clock, aclk, and synchronous active-low aresetn. */
`timescale 1ns/1ns
`include "rsc_map.vh"
module rsc_monitor (
    input wire        aclk,
    input wire        aresetn,
    input wire        sys_reset_n,
    input wire        sys_mgmt_irq_strap_n,
    input wire        bist_strap_n,
    input wire        queue_depth_strap_n,
    input wire [1:0]  cluster_id_strap_n,
    input wire        arb_id_strap_n,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        cfg_valid,
    input wire        cfg_output_tristate,
    input wire        cfg_run_bist,
    input wire        cfg_ioq_depth_one,
    input wire        cfg_mcheck_obs_disable,
    input wire        cfg_businit_obs_disable,
    input wire [1:0]  cfg_cluster_id,
    input wire        cfg_parking_disable,
    input wire        cfg_multithread_disable,
    input wire        cfg_arb_id
);
    // Options gathered so one check covers them all
    wire [9:0] cfg_w = {cfg_arb_id, cfg_multithread_disable, cfg_parking_disable,
        cfg_cluster_id, cfg_businit_obs_disable, cfg_mcheck_obs_disable,
        cfg_ioq_depth_one, cfg_run_bist, cfg_output_tristate};
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Options move only with a fresh capture
    chk_cfg_hold: assert property (!$rose(cfg_valid) |-> $stable(cfg_w))
        else $error("options moved");
    chk_valid_drop: assert property (!sys_reset_n [*5] |-> !cfg_valid)
        else $error("valid up in reset");
    chk_valid_rise: assert property ($rose(sys_reset_n) ##1 sys_reset_n [*3] |->
        cfg_valid)
        else $error("no capture after release");
    chk_valid_cause: assert property ($rose(cfg_valid) |-> $past(sys_reset_n, 3))
        else $error("stray capture");
    // Straps stand still around release: four back is the captured level
    chk_tristate_bist: assert property ($rose(cfg_valid) |->
        cfg_output_tristate == !$past(sys_mgmt_irq_strap_n, 4) &&
        cfg_run_bist == !$past(bist_strap_n, 4))
        else $error("tristate or bist wrong");
    chk_ioq_cap: assert property ($rose(cfg_valid) |->
        cfg_ioq_depth_one == !$past(queue_depth_strap_n, 4))
        else $error("queue depth wrong");
    chk_cluster_cap: assert property ($rose(cfg_valid) |->
        cfg_cluster_id == ~$past(cluster_id_strap_n, 4))
        else $error("cluster id wrong");
    chk_arb_cap: assert property ($rose(cfg_valid) |->
        cfg_arb_id == !$past(arb_id_strap_n, 4))
        else $error("arbitration id wrong");
    chk_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    chk_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    cover property ($rose(cfg_valid));
    cover property (cfg_valid && cfg_cluster_id == 2'h3);
    cover property (s_axi_bvalid && s_axi_bresp == `RSC_RESP_SLVERR);
endmodule
bind rsc_sampler rsc_monitor u_mon (.aclk, .aresetn, .sys_reset_n, .sys_mgmt_irq_strap_n,
    .bist_strap_n, .queue_depth_strap_n, .cluster_id_strap_n, .arb_id_strap_n, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .cfg_valid, .cfg_output_tristate, .cfg_run_bist,
    .cfg_ioq_depth_one, .cfg_mcheck_obs_disable, .cfg_businit_obs_disable, .cfg_cluster_id,
    .cfg_parking_disable, .cfg_multithread_disable, .cfg_arb_id);

// file: verification/rsc_board_model.sv
/* Board logic driving the device reset pin and the straps.
   Assumes pull-ups: released straps read deasserted. */
`timescale 1ns/1ns
module rsc_board_model (
    input  wire         aclk,
    output logic        sys_reset_n,
    output logic [9:0]  strap_n,
    output logic [26:0] rsv_n
);
    // Power-up: reset pin held, nothing strapped
    initial begin
        sys_reset_n = 1'b0;
        strap_n = 10'h3FF;
        rsv_n = 27'h7FFFFFF;
    end
    // Assert reset with the chosen options strapped low
    task automatic hold_reset(input logic [9:0] opt, input logic [26:0] rsv);
        @(posedge aclk);
        sys_reset_n <= 1'b0;
        strap_n <= ~opt;
        rsv_n <= ~rsv;
    endtask
    // Release reset, keep straps a few cycles, then let the pull-ups win
    task automatic release_reset;
        @(posedge aclk);
        sys_reset_n <= 1'b1;
        repeat (6) @(posedge aclk);
        strap_n <= 10'h3FF;
        rsv_n <= 27'h7FFFFFF;
    endtask
endmodule

// file: verification/reset_strap_config_sampler_tb_top.sv
/* Self-checking strap sampler bench: board model and AXI4-Lite tasks.
   Assumes the register map header is on the include path. */
`timescale 1ns/1ns
`include "rsc_map.vh"
module reset_strap_config_sampler_tb_top;
    logic        aclk, aresetn;
    logic [3:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, d;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         sys_reset_n, cfg_valid;
    wire  [9:0]  strap_n, cfg;
    wire  [26:0] rsv_n;
    logic [9:0]  exp_cfg, o;
    logic [1:0]  r;
    int          num_errors, num_checks, cyc;
    rsc_board_model board (.aclk, .sys_reset_n, .strap_n, .rsv_n);
    rsc_sampler DUT (.aclk, .aresetn, .sys_reset_n, .sys_mgmt_irq_strap_n(strap_n[0]),
        .bist_strap_n(strap_n[1]), .queue_depth_strap_n(strap_n[2]),
        .mcheck_obs_disable_strap_n(strap_n[3]), .businit_obs_disable_strap_n(strap_n[4]),
        .cluster_id_strap_n(strap_n[6:5]), .parking_disable_strap_n(strap_n[7]),
        .multithread_disable_strap_n(strap_n[8]), .arb_id_strap_n(strap_n[9]),
        .reserved_strap_n(rsv_n), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_valid,
        .cfg_output_tristate(cfg[0]), .cfg_run_bist(cfg[1]), .cfg_ioq_depth_one(cfg[2]),
        .cfg_mcheck_obs_disable(cfg[3]), .cfg_businit_obs_disable(cfg[4]),
        .cfg_cluster_id(cfg[6:5]), .cfg_parking_disable(cfg[7]),
        .cfg_multithread_disable(cfg[8]), .cfg_arb_id(cfg[9]));
    // ------------------------------------------------------------
    // Clock, watchdog and closing report
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Run needs well under 1000 cycles; 5000 means a hang
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            $display("BAD watchdog expected done seen hang");
            end_of_test;
        end
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // ------------------------------------------------------------
    // Bus and strap tasks
    // ------------------------------------------------------------
    // Address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One board reset: options hold during it, then take the straps
    task automatic cap(input logic [9:0] opt, input logic [26:0] rsv);
        board.hold_reset(opt, rsv);
        repeat (6) @(posedge aclk);
        chk("cfg during reset", {1'b0, exp_cfg}, {cfg_valid, cfg});
        board.release_reset;
        exp_cfg = opt;
        chk("cfg after release", {1'b1, opt}, {cfg_valid, cfg});
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {num_errors, num_checks, cyc} = '0;
        exp_cfg = 10'h000;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // Each option alone, then none, then all (cluster id 3)
        for (int i = 0; i < 12; i++) begin
            o = (i == 10) ? 10'h000 : (i == 11) ? 10'h3FF : (10'h001 << i);
            cap(o, 27'h0);
            rd(`RSC_ADDR_CONFIG);
            chk("config reg", {22'h0, o}, d);
        end
        $display("test each option done");
        // A config write must not touch the options
        wr(`RSC_ADDR_CONFIG, 32'h0);
        chk("config write resp", `RSC_RESP_OKAY, r);
        repeat (10) @(posedge aclk);
        chk("cfg held", {22'h0, 10'h3FF}, {22'h0, cfg});
        rd(`RSC_ADDR_LIVE);
        chk("live straps", 32'h0, d);
        rd(`RSC_ADDR_CONTROL);
        chk("control reads", 32'h0, d);
        $display("test hold done");
        // Two warm resets counted after a count clear
        wr(`RSC_ADDR_CONTROL, 32'h2);
        cap(10'h155, 27'h0);
        cap(10'h0AA, 27'h0);
        rd(`RSC_ADDR_STATUS);
        chk("status two captures", 32'h201, d);
        // A reserved strap is only noted
        cap(10'h0AA, 27'h100);
        rd(`RSC_ADDR_STATUS);
        chk("status reserved", 32'h305, d);
        wr(`RSC_ADDR_CONTROL, 32'h1);
        rd(`RSC_ADDR_STATUS);
        chk("status cleared", 32'h301, d);
        $display("test recapture done");
        // Misaligned addresses are refused
        rd(4'h2);
        chk("bad read resp", `RSC_RESP_SLVERR, r);
        chk("bad read data", 32'h0, d);
        wr(4'h5, 32'h3);
        chk("bad write resp", `RSC_RESP_SLVERR, r);
        $display("test bus errors done");
        end_of_test;
    end
endmodule
